// >>> hw/itm_pkg.sv
// Register map, field layout and mode codes of the three-channel input timer
package itm_pkg;

    // Register indices; byte address is four times the index
    localparam logic [29:0] IDX_CH0_CTL = 30'h008007d1;
    localparam logic [29:0] IDX_CH1_CTL = 30'h00800bd1;
    localparam logic [29:0] IDX_CH2_CTL = 30'h00800cd1;
    localparam logic [29:0] IDX_CH0_CNT = 30'h0080078c;
    localparam logic [29:0] IDX_CH1_CNT = 30'h00800b8c;
    localparam logic [29:0] IDX_CH2_CNT = 30'h00800c8c;
    localparam logic [29:0] IDX_CH0_RL  = 30'h0080078e;
    localparam logic [29:0] IDX_CH1_RL  = 30'h00800b8e;
    localparam logic [29:0] IDX_CH2_RL  = 30'h00800c8e;

    localparam int NUM_CH = 3;

    // Control byte layout in data bits [7:0]; bit k holds printed bit (15 - k)
    localparam int POS_PRS_EN   = 0;
    localparam int POS_TRIG_EN  = 2;
    localparam int POS_CNT_EN   = 4;
    localparam int POS_MODE_LO  = 5;
    localparam int POS_MODE_HI  = 6;

    // Operating modes; high bit clear means fixed period
    localparam logic [1:0] MODE_X4    = 2'b10;
    localparam logic [1:0] MODE_EVENT = 2'b11;

    localparam logic [7:0]  CTL_RESET   = 8'h00;
    localparam logic [15:0] CNT_RESET   = 16'h0000;
    localparam logic [15:0] CNT_MAX     = 16'hffff;
    localparam logic [15:0] CNT_MIN     = 16'h0000;
    localparam logic [15:0] CNT_ONE     = 16'h0001;
    localparam logic [31:0] RDATA_RESET = 32'h0000_0000;

    localparam logic [1:0] RESP_OKAY   = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;

    // Control fields of one channel
    typedef struct packed {
        logic [1:0] mode;
        logic       cnt_en;
        logic       trig_en;
        logic       prs_en;
    } itm_ctl_type;

    // Per-channel event pulses
    typedef struct packed {
        logic underflow;
        logic overflow;
    } itm_evt_type;

endpackage

// >>> hw/itm_top.sv
// Three-channel 16-bit input timer with AXI4-Lite register slave
`timescale 1ns/100ps

module itm_top #(
    parameter int CNT_W = 16
) (
    input  wire logic                         ref_clk,
    input  wire logic                         rst,
    // AXI4-Lite slave
    input  wire logic [31:0]                  s_axi_awaddr,
    input  wire logic                         s_axi_awvalid,
    output logic                              s_axi_awready,
    input  wire logic [31:0]                  s_axi_wdata,
    input  wire logic [3:0]                   s_axi_wstrb,
    input  wire logic                         s_axi_wvalid,
    output logic                              s_axi_wready,
    output logic [1:0]                        s_axi_bresp,
    output logic                              s_axi_bvalid,
    input  wire logic                         s_axi_bready,
    input  wire logic [31:0]                  s_axi_araddr,
    input  wire logic                         s_axi_arvalid,
    output logic                              s_axi_arready,
    output logic [31:0]                       s_axi_rdata,
    output logic [1:0]                        s_axi_rresp,
    output logic                              s_axi_rvalid,
    input  wire logic                         s_axi_rready,
    // Count clock ticks from the prescalers, one cycle each
    input  wire logic [itm_pkg::NUM_CH-1:0]   prescaler_tick,
    // External event inputs
    input  wire logic [itm_pkg::NUM_CH-1:0]   event_input_primary,
    input  wire logic [itm_pkg::NUM_CH-1:0]   event_input_secondary,
    // Prescaler run controls
    output logic                              prescaler_a_enable,
    output logic                              prescaler_b_enable,
    output logic                              prescaler_c_enable,
    // Start triggers to the output-timer groups
    output logic                              output_timer_group_a_channels,
    output logic                              output_timer_group_b_channels,
    // Interrupt request pulses per channel
    output itm_pkg::itm_evt_type [itm_pkg::NUM_CH-1:0] chan_event
);
    import itm_pkg::*;

    // Write channel state
    logic                   aw_full_q;
    logic                   w_full_q;
    logic [29:0]            wr_idx_q;
    logic [31:0]            wr_data_q;
    logic [3:0]             wr_strb_q;
    logic                   awready_q;
    logic                   wready_q;
    logic                   bvalid_q;
    logic [1:0]             bresp_q;
    logic                   do_wr;
    logic                   wr_hit;

    // Read channel state
    logic                   arready_q;
    logic                   rvalid_q;
    logic [31:0]            rdata_q;
    logic [1:0]             rresp_q;
    logic [31:0]            rd_mux;
    logic                   rd_hit;

    // Per-channel views
    logic [NUM_CH-1:0]      wr_ctl;
    logic [NUM_CH-1:0]      wr_cnt;
    logic [NUM_CH-1:0]      wr_rl;
    logic [CNT_W-1:0]       cnt_v [NUM_CH];
    logic [CNT_W-1:0]       rl_v  [NUM_CH];
    itm_ctl_type            ctl_v [NUM_CH];
    itm_evt_type [NUM_CH-1:0] evt_q;
    logic                   trig_a_q;
    logic                   trig_b_q;

    // A write goes ahead once both address and data are held
    assign do_wr = aw_full_q && w_full_q && !bvalid_q;

    // Address acceptance; held off until the response is collected
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            awready_q <= 1'b0;
            aw_full_q <= 1'b0;
            wr_idx_q  <= '0;
        end else if (s_axi_awvalid && awready_q) begin
            awready_q <= 1'b0;
            aw_full_q <= 1'b1;
            wr_idx_q  <= s_axi_awaddr[31:2];
        end else if (do_wr) begin
            aw_full_q <= 1'b0;
        end else if (!aw_full_q && !bvalid_q) begin
            awready_q <= 1'b1;
        end
    end

    // Data acceptance, independent of address order
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            wready_q  <= 1'b0;
            w_full_q  <= 1'b0;
            wr_data_q <= '0;
            wr_strb_q <= '0;
        end else if (s_axi_wvalid && wready_q) begin
            wready_q  <= 1'b0;
            w_full_q  <= 1'b1;
            wr_data_q <= s_axi_wdata;
            wr_strb_q <= s_axi_wstrb;
        end else if (do_wr) begin
            w_full_q <= 1'b0;
        end else if (!w_full_q && !bvalid_q) begin
            wready_q <= 1'b1;
        end
    end

    // Write decode per channel
    always_comb begin
        wr_ctl[0] = do_wr && (wr_idx_q == IDX_CH0_CTL);
        wr_ctl[1] = do_wr && (wr_idx_q == IDX_CH1_CTL);
        wr_ctl[2] = do_wr && (wr_idx_q == IDX_CH2_CTL);
        wr_cnt[0] = do_wr && (wr_idx_q == IDX_CH0_CNT);
        wr_cnt[1] = do_wr && (wr_idx_q == IDX_CH1_CNT);
        wr_cnt[2] = do_wr && (wr_idx_q == IDX_CH2_CNT);
        wr_rl[0]  = do_wr && (wr_idx_q == IDX_CH0_RL);
        wr_rl[1]  = do_wr && (wr_idx_q == IDX_CH1_RL);
        wr_rl[2]  = do_wr && (wr_idx_q == IDX_CH2_RL);
        wr_hit    = |{wr_ctl, wr_cnt, wr_rl};
    end

    // Write response; unmapped addresses answer with an error
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            bvalid_q <= 1'b0;
            bresp_q  <= RESP_OKAY;
        end else if (do_wr) begin
            bvalid_q <= 1'b1;
            bresp_q  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
        end else if (bvalid_q && s_axi_bready) begin
            bvalid_q <= 1'b0;
        end
    end

    // Read decode; reserved control bits come back as zero
    always_comb begin
        rd_mux = RDATA_RESET;
        rd_hit = 1'b1;
        unique case (s_axi_araddr[31:2])
            IDX_CH0_CTL: rd_mux[7:0] = ctl_byte(ctl_v[0]);
            IDX_CH1_CTL: rd_mux[7:0] = ctl_byte(ctl_v[1]);
            IDX_CH2_CTL: rd_mux[7:0] = ctl_byte(ctl_v[2]);
            IDX_CH0_CNT: rd_mux[15:0] = cnt_v[0];
            IDX_CH1_CNT: rd_mux[15:0] = cnt_v[1];
            IDX_CH2_CNT: rd_mux[15:0] = cnt_v[2];
            IDX_CH0_RL:  rd_mux[15:0] = rl_v[0];
            IDX_CH1_RL:  rd_mux[15:0] = rl_v[1];
            IDX_CH2_RL:  rd_mux[15:0] = rl_v[2];
            default:     rd_hit = 1'b0;
        endcase
    end

    // Read address and data; one read in flight at a time
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            arready_q <= 1'b0;
            rvalid_q  <= 1'b0;
            rdata_q   <= RDATA_RESET;
            rresp_q   <= RESP_OKAY;
        end else if (s_axi_arvalid && arready_q) begin
            arready_q <= 1'b0;
            rvalid_q  <= 1'b1;
            rdata_q   <= rd_mux;
            rresp_q   <= rd_hit ? RESP_OKAY : RESP_SLVERR;
        end else if (rvalid_q && s_axi_rready) begin
            rvalid_q <= 1'b0;
        end else if (!rvalid_q) begin
            arready_q <= 1'b1;
        end
    end

    // Pack control fields into the byte that software sees
    function automatic logic [7:0] ctl_byte(input itm_ctl_type c);
        logic [7:0] b;
        b = CTL_RESET;
        b[POS_PRS_EN]  = c.prs_en;
        b[POS_TRIG_EN] = c.trig_en;
        b[POS_CNT_EN]  = c.cnt_en;
        b[POS_MODE_LO] = c.mode[0];
        b[POS_MODE_HI] = c.mode[1];
        return b;
    endfunction

    // One timer channel per loop pass
    for (genvar i = 0; i < NUM_CH; i++) begin : g_ch
        itm_ctl_type       ctl_q;
        logic [CNT_W-1:0]  cnt_q;
        logic [CNT_W-1:0]  rl_q;
        logic              loaded_q;
        logic              pri_q;
        logic              sec_q;
        logic              pri_edge;
        logic              sec_edge;
        logic              step_up;
        logic              step_dn;
        logic              load;
        logic              uf;
        logic              ov;
        itm_evt_type       evt_ch_q;

        assign evt_q[i] = evt_ch_q;
        assign ctl_v[i] = ctl_q;
        assign cnt_v[i] = cnt_q;
        assign rl_v[i]  = rl_q;

        // Control byte; only assigned bits are stored
        always_ff @(posedge ref_clk) begin
            if (rst) begin
                ctl_q <= '0;
            end else if (wr_ctl[i] && wr_strb_q[0]) begin
                ctl_q.mode[1] <= wr_data_q[POS_MODE_HI];
                ctl_q.mode[0] <= wr_data_q[POS_MODE_LO];
                ctl_q.cnt_en  <= wr_data_q[POS_CNT_EN];
                ctl_q.prs_en  <= wr_data_q[POS_PRS_EN];
                // Channel 0 has no trigger output
                ctl_q.trig_en <= (i != 0) && wr_data_q[POS_TRIG_EN];
            end
        end

        // Reload register, byte lanes honoured
        always_ff @(posedge ref_clk) begin
            if (rst) begin
                rl_q <= CNT_RESET;
            end else if (wr_rl[i]) begin
                if (wr_strb_q[0]) rl_q[7:0]  <= wr_data_q[7:0];
                if (wr_strb_q[1]) rl_q[15:8] <= wr_data_q[15:8];
            end
        end

        // Previous input levels for edge detection
        always_ff @(posedge ref_clk) begin
            if (rst) begin
                pri_q <= 1'b0;
                sec_q <= 1'b0;
            end else begin
                pri_q <= event_input_primary[i];
                sec_q <= event_input_secondary[i];
            end
        end

        assign pri_edge = event_input_primary[i] ^ pri_q;
        assign sec_edge = event_input_secondary[i] ^ sec_q;

        // Step decision per mode
        always_comb begin
            step_up = 1'b0;
            step_dn = 1'b0;
            load    = 1'b0;
            if (ctl_q.cnt_en) begin
                if (!ctl_q.mode[1]) begin
                    if (prescaler_tick[i]) begin
                        // First tick after enable loads, as does underflow
                        load    = !loaded_q || (cnt_q == CNT_MIN);
                        step_dn = !load;
                    end
                end else if (ctl_q.mode == MODE_EVENT) begin
                    step_up = pri_edge;
                end else begin
                    // Simultaneous edges on both inputs are ambiguous, so skipped
                    if (pri_edge && !sec_edge) begin
                        step_up = event_input_primary[i] != sec_q;
                        step_dn = event_input_primary[i] == sec_q;
                    end else if (sec_edge && !pri_edge) begin
                        step_up = event_input_secondary[i] == pri_q;
                        step_dn = event_input_secondary[i] != pri_q;
                    end
                end
            end
            uf = (step_dn && (cnt_q == CNT_MIN) && ctl_q.mode[1])
               || (load && loaded_q);
            ov = step_up && (cnt_q == CNT_MAX);
        end

        // Marks that the enable-time load has happened
        always_ff @(posedge ref_clk) begin
            if (rst) begin
                loaded_q <= 1'b0;
            end else if (!ctl_q.cnt_en) begin
                loaded_q <= 1'b0;
            end else if (load) begin
                loaded_q <= 1'b1;
            end
        end

        // Counter; a software write wins over counting
        always_ff @(posedge ref_clk) begin
            if (rst) begin
                cnt_q <= CNT_RESET;
            end else if (wr_cnt[i] && (wr_strb_q[0] || wr_strb_q[1])) begin
                if (wr_strb_q[0]) cnt_q[7:0]  <= wr_data_q[7:0];
                if (wr_strb_q[1]) cnt_q[15:8] <= wr_data_q[15:8];
            end else if (load) begin
                cnt_q <= rl_q;
            end else if (step_up) begin
                cnt_q <= cnt_q + CNT_ONE;
            end else if (step_dn) begin
                cnt_q <= cnt_q - CNT_ONE;
            end
        end

        // Event pulses, one cycle each
        always_ff @(posedge ref_clk) begin
            if (rst) begin
                evt_ch_q <= '0;
            end else begin
                evt_ch_q.underflow <= uf;
                evt_ch_q.overflow  <= ov;
            end
        end
    end

    // Start triggers gated by each channel's trigger enable
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            trig_a_q <= 1'b0;
            trig_b_q <= 1'b0;
        end else begin
            trig_a_q <= ctl_v[1].trig_en && (|g_ch[1].uf || |g_ch[1].ov);
            trig_b_q <= ctl_v[2].trig_en && (|g_ch[2].uf || |g_ch[2].ov);
        end
    end

    // Outputs straight from flip-flops
    assign s_axi_awready = awready_q;
    assign s_axi_wready  = wready_q;
    assign s_axi_bvalid  = bvalid_q;
    assign s_axi_bresp   = bresp_q;
    assign s_axi_arready = arready_q;
    assign s_axi_rvalid  = rvalid_q;
    assign s_axi_rdata   = rdata_q;
    assign s_axi_rresp   = rresp_q;
    assign prescaler_a_enable = ctl_v[0].prs_en;
    assign prescaler_b_enable = ctl_v[1].prs_en;
    assign prescaler_c_enable = ctl_v[2].prs_en;
    assign output_timer_group_a_channels = trig_a_q;
    assign output_timer_group_b_channels = trig_b_q;
    assign chan_event = evt_q;

endmodule // itm_top

// >>> bench/itm_top_props.sv
// Concurrent checks on the register port and timer outputs of the input timer
`timescale 1ns/100ps

module itm_top_props (
    input wire logic                       ref_clk,
    input wire logic                       rst,
    input wire logic                       s_axi_awvalid,
    input wire logic                       s_axi_awready,
    input wire logic                       s_axi_wvalid,
    input wire logic                       s_axi_wready,
    input wire logic                       s_axi_bvalid,
    input wire logic                       s_axi_bready,
    input wire logic                       s_axi_arvalid,
    input wire logic                       s_axi_arready,
    input wire logic [31:0]                s_axi_rdata,
    input wire logic                       s_axi_rvalid,
    input wire logic                       s_axi_rready,
    input wire logic [itm_pkg::NUM_CH-1:0] prescaler_tick,
    input wire logic [itm_pkg::NUM_CH-1:0] event_input_primary,
    input wire logic [itm_pkg::NUM_CH-1:0] event_input_secondary,
    input wire logic                       prescaler_a_enable,
    input wire logic                       prescaler_b_enable,
    input wire logic                       prescaler_c_enable,
    input wire logic                       output_timer_group_a_channels,
    input wire logic                       output_timer_group_b_channels,
    input wire itm_pkg::itm_evt_type [itm_pkg::NUM_CH-1:0] chan_event
);
    import itm_pkg::*;

    logic [NUM_CH-1:0]   prim_q, sec_q, act, recent, evt_any;
    logic [3*NUM_CH-1:0] hist_q;

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);

    // Last input levels for edges; three cycles of history cover tick-to-pulse delay
    always_ff @(posedge ref_clk) begin
        prim_q <= event_input_primary;
        sec_q  <= event_input_secondary;
        if (rst) begin
            hist_q <= '0;
        end else begin
            hist_q <= {hist_q[2*NUM_CH-1:0], act};
        end
    end

    // Activity and pulses folded per channel
    assign act = prescaler_tick | (event_input_primary ^ prim_q) | (event_input_secondary ^ sec_q);
    assign recent = hist_q[NUM_CH-1:0] | hist_q[2*NUM_CH-1:NUM_CH] | hist_q[3*NUM_CH-1:2*NUM_CH];
    always_comb begin
        for (int k = 0; k < NUM_CH; k++) begin
            evt_any[k] = chan_event[k].underflow | chan_event[k].overflow;
        end
    end

    ar_to_r_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer late");
    r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped");
    w_to_b_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
        |-> ##[1:2] s_axi_bvalid) else $error("write answer late");
    b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
        else $error("write answer dropped");
    aw_block_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write taken during answer");
    prs_write_a: assert property ($changed({prescaler_c_enable, prescaler_b_enable,
        prescaler_a_enable}) |-> $rose(s_axi_bvalid) || $past(rst)) else $error("prescaler moved");
    trig_a_gate_a: assert property (output_timer_group_a_channels |-> evt_any[1])
        else $error("group a trigger without event");
    trig_b_gate_a: assert property (output_timer_group_b_channels |-> evt_any[2])
        else $error("group b trigger without event");
    evt_cause_a: assert property (|evt_any |-> (evt_any & ~recent) == '0)
        else $error("event pulse without count step");
endmodule // itm_top_props

bind itm_top itm_top_props u_props (.*);

// >>> bench/itm_partner.sv
// Far-side model: prescaler ticks, event pins and output-timer trigger sinks
`timescale 1ns/100ps

module itm_partner (
    input  wire logic                       ref_clk,
    input  wire logic [itm_pkg::NUM_CH-1:0] run,
    input  wire logic [1:0]                 trig,
    input  wire itm_pkg::itm_evt_type [itm_pkg::NUM_CH-1:0] chan_event,
    output logic [itm_pkg::NUM_CH-1:0]      prescaler_tick,
    output logic [itm_pkg::NUM_CH-1:0]      event_input_primary,
    output logic [itm_pkg::NUM_CH-1:0]      event_input_secondary
);
    import itm_pkg::*;

    int trig_n [2]      = '{default: 0};
    int unf_n  [NUM_CH] = '{default: 0};
    int ovf_n  [NUM_CH] = '{default: 0};

    initial begin
        prescaler_tick        = '0;
        event_input_primary   = '0;
        event_input_secondary = '0;
    end

    // Pulses last one cycle, so each sampled high is one event
    always @(posedge ref_clk) begin
        for (int k = 0; k < NUM_CH; k++) begin
            unf_n[k] <= unf_n[k] + int'(chan_event[k].underflow);
            ovf_n[k] <= ovf_n[k] + int'(chan_event[k].overflow);
        end
        trig_n[0] <= trig_n[0] + int'(trig[0]);
        trig_n[1] <= trig_n[1] + int'(trig[1]);
    end

    // A stopped prescaler gives no count clock
    task automatic tick(input int ch);
        @(posedge ref_clk);
        if (run[ch] === 1'b1) begin
            prescaler_tick[ch] <= 1'b1;
        end
        @(posedge ref_clk);
        prescaler_tick[ch] <= 1'b0;
        repeat (3) @(posedge ref_clk);
    endtask

    // One pin of the pair moves at a time, never both in one cycle
    task automatic flip(input int ch, input bit sec);
        @(posedge ref_clk);
        if (sec) begin
            event_input_secondary[ch] <= ~event_input_secondary[ch];
        end else begin
            event_input_primary[ch] <= ~event_input_primary[ch];
        end
        repeat (3) @(posedge ref_clk);
    endtask
endmodule // itm_partner

// >>> bench/itm_top_test.sv
// Self-checking bench for the three-channel input timer
`timescale 1ns/100ps

module itm_top_test;
    import itm_pkg::*;

    localparam logic [29:0] CTL [NUM_CH] = '{IDX_CH0_CTL, IDX_CH1_CTL, IDX_CH2_CTL};
    localparam logic [29:0] CNT [NUM_CH] = '{IDX_CH0_CNT, IDX_CH1_CNT, IDX_CH2_CNT};
    localparam logic [29:0] RL  [NUM_CH] = '{IDX_CH0_RL, IDX_CH1_RL, IDX_CH2_RL};
    localparam logic [29:0] IDX_NONE     = 30'h008007d2;
    localparam bit          X4_SEQ [6]   = '{1'b0, 1'b1, 1'b0, 1'b1, 1'b1, 1'b0};

    logic              ref_clk, rst;
    logic [31:0]       s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata;
    logic [3:0]        s_axi_wstrb;
    logic [1:0]        s_axi_bresp, s_axi_rresp;
    logic              s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic              s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
    logic              s_axi_rvalid, s_axi_rready, prescaler_a_enable, prescaler_b_enable;
    logic              prescaler_c_enable, output_timer_group_a_channels;
    logic              output_timer_group_b_channels;
    logic [NUM_CH-1:0] prescaler_tick, event_input_primary, event_input_secondary;
    itm_evt_type [NUM_CH-1:0] chan_event;
    int                err_count;
    int                checks_done;

    itm_top dut (.*);

    itm_partner fs (.run({prescaler_c_enable, prescaler_b_enable, prescaler_a_enable}),
        .trig({output_timer_group_b_channels, output_timer_group_a_channels}), .*);

    initial begin
        ref_clk = 1'b0;
        forever #2.5 ref_clk = ~ref_clk;
    end

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        checks_done++;
        if (got !== exp) begin
            $display("wrong value %s expected %h seen %h", what, exp, got);
            err_count++;
        end
    endtask

    // Address and data offered together, each released when taken
    task automatic wr(input logic [29:0] idx, input logic [31:0] d, input logic [3:0] strb,
                      input logic [1:0] resp);
        int n = 0;
        @(posedge ref_clk);
        s_axi_awaddr  <= {idx, 2'b00};
        s_axi_wdata   <= d;
        s_axi_wstrb   <= strb;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid  <= 1'b1;
        s_axi_bready  <= 1'b1;
        do begin
            @(posedge ref_clk);
            if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
            if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
            if (++n > 40) begin
                err_count++;
                report_and_stop();
            end
        end while (s_axi_bvalid !== 1'b1);
        s_axi_bready <= 1'b0;
        check("write response", 32'(resp), 32'(s_axi_bresp));
    endtask

    task automatic rd(input logic [29:0] idx, input logic [31:0] exp, input logic [1:0] resp,
                      input string what);
        int n = 0;
        @(posedge ref_clk);
        s_axi_araddr  <= {idx, 2'b00};
        s_axi_arvalid <= 1'b1;
        s_axi_rready  <= 1'b1;
        do begin
            @(posedge ref_clk);
            if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
            if (++n > 40) begin
                err_count++;
                report_and_stop();
            end
        end while (s_axi_rvalid !== 1'b1);
        s_axi_rready <= 1'b0;
        check(what, exp, s_axi_rdata);
        check("read response", 32'(resp), 32'(s_axi_rresp));
    endtask

    // One fixed-period run: load, underflow, stop, reload on enable
    task automatic fx(input int ch, input logic trig, input logic mlo);
        int a0, b0, u0;
        logic [31:0] base;
        a0 = fs.trig_n[0];
        b0 = fs.trig_n[1];
        u0 = fs.unf_n[ch];
        base = {26'h0, mlo, 5'h01};
        wr(CTL[ch], base, 4'b0001, RESP_OKAY);
        wr(RL[ch], 32'h2, 4'b0011, RESP_OKAY);
        wr(CTL[ch], base | 32'h10 | {29'h0, trig, 2'b00}, 4'b0001, RESP_OKAY);
        repeat (3) fs.tick(ch);
        rd(CNT[ch], 32'h0, RESP_OKAY, "counter at zero");
        fs.tick(ch);
        rd(CNT[ch], 32'h2, RESP_OKAY, "counter reloaded");
        check("underflows", 32'h1, 32'(fs.unf_n[ch] - u0));
        check("group a", {31'h0, trig && ch == 1}, 32'(fs.trig_n[0] - a0));
        check("group b", {31'h0, trig && ch == 2}, 32'(fs.trig_n[1] - b0));
        wr(CTL[ch], base, 4'b0001, RESP_OKAY);
        repeat (2) fs.tick(ch);
        rd(CNT[ch], 32'h2, RESP_OKAY, "stopped counter");
        wr(RL[ch], 32'h4, 4'b0011, RESP_OKAY);
        rd(CNT[ch], 32'h2, RESP_OKAY, "counter after reload write");
        wr(CTL[ch], base | 32'h10, 4'b0001, RESP_OKAY);
        fs.tick(ch);
        rd(CNT[ch], 32'h4, RESP_OKAY, "counter loaded on enable");
        wr(CTL[ch], base, 4'b0001, RESP_OKAY);
        wr(CTL[ch], 32'h0, 4'b0001, RESP_OKAY);
        $display("test fixed period channel %0d done", ch);
    endtask

    initial begin
        int o0, u0;
        rst = 1'b1;
        {s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_wstrb} = '0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
        err_count = 0;
        checks_done = 0;
        repeat (3) @(posedge ref_clk);
        rst <= 1'b0;
        // Control reset value, read/write access and reserved control bits
        for (int ch = 0; ch < NUM_CH; ch++) begin
            rd(CTL[ch], 32'h0, RESP_OKAY, "control reset");
            wr(CNT[ch], 32'h0000_a5c3, 4'b0011, RESP_OKAY);
            wr(RL[ch], 32'h0000_3c5a, 4'b0011, RESP_OKAY);
            rd(CNT[ch], 32'h0000_a5c3, RESP_OKAY, "counter");
            rd(RL[ch], 32'h0000_3c5a, RESP_OKAY, "reload");
            wr(CTL[ch], 32'h0000_009f, 4'b0001, RESP_OKAY);
            rd(CTL[ch], (ch == 0) ? 32'h11 : 32'h15, RESP_OKAY, "control");
            check("prescaler enables", 32'h1 << ch, {29'h0, fs.run});
            wr(CTL[ch], 32'h0, 4'b0001, RESP_OKAY);
        end
        wr(IDX_NONE, 32'hffff_ffff, 4'b1111, RESP_SLVERR);
        rd(IDX_NONE, 32'h0, RESP_SLVERR, "unmapped");
        $display("test registers done");
        fx(0, 1'b1, 1'b0);
        fx(1, 1'b1, 1'b0);
        fx(1, 1'b0, 1'b0);
        fx(2, 1'b0, 1'b1);
        fx(2, 1'b1, 1'b0);
        // Plain event count on channel 0 across the top of the range
        o0 = fs.ovf_n[0];
        wr(CTL[0], 32'h60, 4'b0001, RESP_OKAY);
        rd(CTL[0], 32'h60, RESP_OKAY, "event mode");
        wr(CNT[0], 32'h0000_fffe, 4'b0011, RESP_OKAY);
        wr(CTL[0], 32'h70, 4'b0001, RESP_OKAY);
        repeat (3) fs.flip(0, 1'b0);
        fs.flip(0, 1'b1);
        rd(CNT[0], 32'h1, RESP_OKAY, "event count");
        check("overflows", 32'h1, 32'(fs.ovf_n[0] - o0));
        wr(CTL[0], 32'h60, 4'b0001, RESP_OKAY);
        fs.flip(0, 1'b0);
        rd(CNT[0], 32'h1, RESP_OKAY, "stopped event count");
        wr(CTL[0], 32'h0, 4'b0001, RESP_OKAY);
        $display("test event count done");
        // Times-four on channel 2: four up, two down, then both wraps
        o0 = fs.ovf_n[2];
        u0 = fs.unf_n[2];
        wr(CTL[2], 32'h40, 4'b0001, RESP_OKAY);
        rd(CTL[2], 32'h40, RESP_OKAY, "x4 mode");
        wr(CNT[2], 32'h1, 4'b0011, RESP_OKAY);
        wr(CTL[2], 32'h50, 4'b0001, RESP_OKAY);
        foreach (X4_SEQ[i]) fs.flip(2, X4_SEQ[i]);
        rd(CNT[2], 32'h3, RESP_OKAY, "x4 up and down");
        wr(CNT[2], 32'h0, 4'b0011, RESP_OKAY);
        fs.flip(2, 1'b1);
        rd(CNT[2], 32'hffff, RESP_OKAY, "x4 underflow");
        fs.flip(2, 1'b1);
        rd(CNT[2], 32'h0, RESP_OKAY, "x4 overflow");
        check("x4 underflows", 32'h1, 32'(fs.unf_n[2] - u0));
        check("x4 overflows", 32'h1, 32'(fs.ovf_n[2] - o0));
        $display("test x4 count done");
        report_and_stop();
    end
endmodule // itm_top_test
